// ### shared/emb_pkg.sv
`default_nettype none
package emb_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned EPROM_AW = 15;
    localparam int unsigned RAM_IDX_W = 9;
    localparam int unsigned RAM0_BYTES = 192;
    localparam int unsigned RAM1_BYTES = 256;
    localparam int unsigned RAM_BYTES = RAM0_BYTES + RAM1_BYTES;
    localparam logic [15:0] RAM0_LAST = 16'h00bf;
    localparam logic [15:0] SFR_FIRST = 16'h00c0;
    localparam logic [15:0] SFR_LAST = 16'h00ff;
    localparam logic [15:0] RAM1_FIRST = 16'h0100;
    localparam logic [15:0] RAM1_LAST = 16'h01ff;
    localparam logic [15:0] EPROM_FIRST = 16'h8000;
    localparam logic [8:0] RAM1_IDX_BASE = 9'h0c0;
    localparam logic [8:0] RAM_IDX_LIMIT = 9'h1c0;
    // Timing clock is the oscillator divided by this
    localparam int unsigned TIMING_DIV = 4;
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic [1:0] PH_START = 2'h3;
    localparam logic [1:0] PH_STROBE = 2'h0;
    localparam logic [1:0] PH_WR_END = 2'h2;
    localparam logic [1:0] PH_LAST = 2'h3;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [14:0] EADDR_RESET = 15'h0000;

    typedef enum logic [1:0] {EMB_RAM, EMB_SFR, EMB_EPROM, EMB_EXT}
        emb_region_type;

    function automatic emb_region_type emb_decode(input logic [15:0] a);
        if (a >= EPROM_FIRST)
            return EMB_EPROM;
        else if (a <= RAM0_LAST)
            return EMB_RAM;
        else if (a <= SFR_LAST)
            return EMB_SFR;
        else if (a <= RAM1_LAST)
            return EMB_RAM;
        else
            return EMB_EXT;
    endfunction

    function automatic logic [8:0] emb_ram_index(input logic [15:0] a);
        if (a[8])
            return {1'b0, a[7:0]} + RAM1_IDX_BASE;
        else
            return a[8:0];
    endfunction
endpackage
`default_nettype wire

// ### shared/emb_ram_if.sv
`timescale 1ns/1ps
`default_nettype none
interface emb_ram_if;
    logic we;
    logic [8:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output idx, output wdata, input rdata);
    modport mem (input we, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// ### logic/emb_ram.sv
`timescale 1ns/1ps
`default_nettype none
module emb_ram
    import emb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    emb_ram_if.mem ram
);
    typedef struct packed {
        logic [RAM_BYTES-1:0][7:0] mem;
        logic [7:0] rdata;
    } emb_ram_state_type;

    emb_ram_state_type s_q;
    emb_ram_state_type s_d;

    always_comb
    begin
        s_d = s_q;
        if (ram.we && ram.idx < RAM_IDX_LIMIT)
            s_d.mem[ram.idx] = ram.wdata;
        if (ram.idx < RAM_IDX_LIMIT)
            s_d.rdata = s_q.mem[ram.idx];
        else
            s_d.rdata = BYTE_RESET;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign ram.rdata = s_q.rdata;

    ram_readback_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ram.we && ram.idx < RAM_IDX_LIMIT ##1 ram.idx == $past(ram.idx)
        |=> ram.rdata == $past(ram.wdata, 2))
        else $error("RAM byte did not read back");
endmodule
`default_nettype wire

// ### logic/emb_bus_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module emb_bus_ctrl
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic processor_mode_pin,
    input wire logic cpu_req,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_we,
    input wire logic cpu_fetch,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_ack,
    output emb_pkg::emb_region_type cpu_region,
    input wire logic [7:0] sfr_rdata,
    output logic sfr_write,
    output logic [7:0] sfr_wdata,
    output logic [7:0] sfr_addr,
    output logic timing_clock_out,
    output logic sync_out,
    output logic rw_out,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic reset_out,
    output logic [14:0] eprom_address_port,
    input wire logic [7:0] eprom_data_port,
    output logic [7:0] low_address_port,
    output logic low_address_oe_n,
    output logic [7:0] high_address_port,
    output logic high_address_oe_n,
    input wire logic [7:0] external_data_bus_port_in,
    output logic [7:0] external_data_bus_port_out,
    output logic external_data_bus_port_oe_n
);
    import emb_pkg::*;

    typedef enum logic {EMB_IDLE, EMB_BUSY} emb_state_type;

    typedef struct packed {
        emb_state_type state;
        logic [1:0] div;
        logic phi;
        logic mode_meta;
        logic mode_sync;
        logic mode_armed;
        logic arm_wait;
        logic ext_mode;
        logic [7:0] epd_meta;
        logic [7:0] epd_sync;
        logic [7:0] xd_meta;
        logic [7:0] xd_sync;
        logic [15:0] addr;
        logic we;
        emb_region_type region;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic ack;
        logic sfr_wr;
        logic sync;
        logic rw;
        logic rd_n;
        logic wr_n;
        logic rst_out;
        logic [14:0] eaddr;
        logic [7:0] lo;
        logic [7:0] hi;
        logic addr_oe_n;
        logic [7:0] xd_out;
        logic xd_oe_n;
    } emb_bus_state_type;

    localparam emb_bus_state_type STATE_RESET = '{
        state: EMB_IDLE, div: DIV_RESET, phi: 1'b0, mode_meta: 1'b0,
        mode_sync: 1'b0, mode_armed: 1'b0, arm_wait: 1'b0,
        ext_mode: 1'b0,
        epd_meta: BYTE_RESET, epd_sync: BYTE_RESET, xd_meta: BYTE_RESET,
        xd_sync: BYTE_RESET, addr: ADDR_RESET, we: 1'b0, region: EMB_RAM,
        wdata: BYTE_RESET, rdata: BYTE_RESET, ack: 1'b0, sfr_wr: 1'b0,
        sync: 1'b0, rw: 1'b1, rd_n: 1'b1, wr_n: 1'b1, rst_out: 1'b1,
        eaddr: EADDR_RESET, lo: BYTE_RESET, hi: BYTE_RESET,
        addr_oe_n: 1'b1, xd_out: BYTE_RESET, xd_oe_n: 1'b1};

    emb_bus_state_type s_q;
    emb_bus_state_type s_d;
    emb_region_type req_region;
    logic ext_access;

    emb_ram_if ram_bus ();

    emb_ram u_ram (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ram(ram_bus.mem)
    );

    assign req_region = emb_decode(cpu_addr);
    assign ext_access = s_q.region == EMB_EXT && s_q.ext_mode;

    // ----------------------------------------------------------------
    // RAM port
    // ----------------------------------------------------------------
    assign ram_bus.idx = emb_ram_index(s_q.addr);
    assign ram_bus.wdata = s_q.wdata;
    assign ram_bus.we = s_q.state == EMB_BUSY && s_q.div == PH_LAST &&
        s_q.we && s_q.region == EMB_RAM;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.sfr_wr = 1'b0;
        s_d.rst_out = 1'b0;
        s_d.div = s_q.div + 2'h1;
        s_d.phi = s_d.div[1];
        // Pin inputs through two flops
        s_d.mode_meta = processor_mode_pin;
        s_d.mode_sync = s_q.mode_meta;
        s_d.epd_meta = eprom_data_port;
        s_d.epd_sync = s_q.epd_meta;
        s_d.xd_meta = external_data_bus_port_in;
        s_d.xd_sync = s_q.xd_meta;
        // Mode strap caught once a post-reset pin sample is synced
        if (s_q.rst_out == 1'b0)
            s_d.arm_wait = 1'b1;
        if (!s_q.mode_armed && s_q.arm_wait)
        begin
            s_d.mode_armed = 1'b1;
            s_d.ext_mode = s_q.mode_sync;
            s_d.addr_oe_n = !s_q.mode_sync;
        end
        unique case (s_q.state)
            EMB_IDLE:
            begin
                if (cpu_req && s_q.div == PH_START && s_q.mode_armed)
                begin
                    s_d.state = EMB_BUSY;
                    s_d.addr = cpu_addr;
                    s_d.we = cpu_we;
                    s_d.wdata = cpu_wdata;
                    s_d.region = req_region;
                    s_d.sync = cpu_fetch && !cpu_we;
                    s_d.rw = !cpu_we;
                    if (req_region == EMB_EPROM)
                        s_d.eaddr = cpu_addr[14:0];
                    if (s_q.ext_mode)
                    begin
                        s_d.lo = cpu_addr[7:0];
                        s_d.hi = cpu_addr[15:8];
                    end
                    if (s_q.ext_mode && req_region == EMB_EXT && cpu_we)
                    begin
                        s_d.xd_out = cpu_wdata;
                        s_d.xd_oe_n = 1'b0;
                    end
                end
            end
            EMB_BUSY:
            begin
                if (s_q.div == PH_STROBE && ext_access)
                begin
                    s_d.rd_n = s_q.we;
                    s_d.wr_n = !s_q.we;
                end
                if (s_q.div == PH_WR_END)
                    s_d.wr_n = 1'b1;
                if (s_q.div == PH_LAST)
                begin
                    s_d.state = EMB_IDLE;
                    s_d.ack = 1'b1;
                    s_d.rd_n = 1'b1;
                    s_d.sync = 1'b0;
                    s_d.rw = 1'b1;
                    s_d.xd_oe_n = 1'b1;
                    s_d.sfr_wr = s_q.we && s_q.region == EMB_SFR;
                    unique case (s_q.region)
                        EMB_RAM: s_d.rdata = ram_bus.rdata;
                        EMB_SFR: s_d.rdata = sfr_rdata;
                        EMB_EPROM: s_d.rdata = s_q.epd_sync;
                        EMB_EXT: s_d.rdata = ext_access ? s_q.xd_sync
                                                        : BYTE_RESET;
                    endcase
                    if (s_q.we)
                        s_d.rdata = BYTE_RESET;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            s_q <= STATE_RESET;
        else
            s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign cpu_rdata = s_q.rdata;
    assign cpu_ack = s_q.ack;
    assign cpu_region = s_q.region;
    assign sfr_write = s_q.sfr_wr;
    assign sfr_wdata = s_q.wdata;
    assign sfr_addr = s_q.addr[7:0];
    assign timing_clock_out = s_q.phi;
    assign sync_out = s_q.sync;
    assign rw_out = s_q.rw;
    assign read_strobe_n = s_q.rd_n;
    assign write_strobe_n = s_q.wr_n;
    assign reset_out = s_q.rst_out;
    assign eprom_address_port = s_q.eaddr;
    assign low_address_port = s_q.lo;
    assign high_address_port = s_q.hi;
    assign low_address_oe_n = s_q.addr_oe_n;
    assign high_address_oe_n = s_q.addr_oe_n;
    assign external_data_bus_port_out = s_q.xd_out;
    assign external_data_bus_port_oe_n = s_q.xd_oe_n;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    eprom_decode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_q.state == EMB_BUSY |-> s_q.addr[15] == (s_q.region == EMB_EPROM))
        else $error("EPROM region decode wrong");

    ram_decode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_q.state == EMB_BUSY |-> (s_q.region == EMB_RAM) ==
        (s_q.addr <= RAM0_LAST ||
         (s_q.addr >= RAM1_FIRST && s_q.addr <= RAM1_LAST)))
        else $error("RAM region decode wrong");

    eprom_addr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_q.state == EMB_BUSY && s_q.region == EMB_EPROM
        |-> eprom_address_port == s_q.addr[14:0])
        else $error("EPROM address mismatch");

    phi_quarter_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(timing_clock_out) |-> ##1 !$rose(timing_clock_out)
        ##1 !$rose(timing_clock_out) ##1 !$rose(timing_clock_out)
        ##1 $rose(timing_clock_out))
        else $error("Timing clock not divided by four");

    fetch_mark_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_q.state == EMB_IDLE && s_q.div == PH_START && s_q.mode_armed &&
        cpu_req && cpu_fetch && !cpu_we |=> sync_out [*4] ##1 !sync_out)
        else $error("Fetch marker wrong length");

    write_dir_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !write_strobe_n |-> !rw_out && !external_data_bus_port_oe_n)
        else $error("Write strobe without write direction");

    read_strobe_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(read_strobe_n) |-> rw_out && s_q.region == EMB_EXT &&
        s_q.ext_mode ##1 !read_strobe_n ##1 !read_strobe_n ##1 read_strobe_n)
        else $error("Read strobe misplaced");

    reset_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reset_out |=> !reset_out [*2])
        else $error("Reset output stuck after reset");

    single_chip_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_q.mode_armed && !s_q.ext_mode |-> low_address_oe_n &&
        high_address_oe_n && external_data_bus_port_oe_n && read_strobe_n)
        else $error("Bus pins driven in single-chip mode");

    eprom_data_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_q.ack && !s_q.we && s_q.region == EMB_EPROM
        |-> cpu_rdata == $past(s_q.epd_sync))
        else $error("EPROM read data not taken");
endmodule
`default_nettype wire

// ### tb/emb_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module emb_ext_model
(
    input wire logic ref_clk,
    input wire logic [14:0] eprom_address_port,
    output logic [7:0] eprom_data_port,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] low_address_port,
    input wire logic [7:0] external_data_bus_port_out,
    input wire logic external_data_bus_port_oe_n,
    output logic [7:0] external_data_bus_port_in
);
    logic [7:0] mem [256];
    logic [7:0] last_q = 8'h00;
    initial
        foreach (mem[i])
            mem[i] = 8'h5a;
    // EPROM byte is a fixed pattern of its address
    assign eprom_data_port = eprom_address_port[7:0]
        ^ {1'b0, eprom_address_port[14:8]};
    // Released bus shows the inverse of the last byte read
    assign external_data_bus_port_in = !read_strobe_n
        ? mem[low_address_port] : ~last_q;
    always @(posedge ref_clk)
    begin
        if (!read_strobe_n)
            last_q <= mem[low_address_port];
        if (!write_strobe_n && !external_data_bus_port_oe_n)
            mem[low_address_port] <= external_data_bus_port_out;
    end
endmodule
`default_nettype wire

// ### tb/emb_bus_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module emb_bus_ctrl_test;
    import emb_pkg::*;
    logic ref_clk = 0, reset_n = 0, processor_mode_pin = 1, cpu_req = 0;
    logic cpu_we = 0, cpu_fetch = 0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] cpu_wdata = 8'h00, sfr_rdata = 8'h00, cpu_rdata;
    logic [7:0] low_address_port, high_address_port, eprom_data_port;
    logic [7:0] external_data_bus_port_in, external_data_bus_port_out;
    logic [7:0] sfr_wdata, sfr_addr;
    logic cpu_ack, sfr_write, timing_clock_out, sync_out, rw_out, reset_out;
    logic read_strobe_n, write_strobe_n, low_address_oe_n;
    logic high_address_oe_n, external_data_bus_port_oe_n;
    logic [14:0] eprom_address_port;
    emb_region_type cpu_region;
    logic [5:0] seen;
    int n_mismatch = 0, checked = 0, lat;

    always #2.5 ref_clk = ~ref_clk;

    emb_bus_ctrl u_dut (.ref_clk, .reset_n, .processor_mode_pin, .cpu_req,
        .cpu_addr, .cpu_we, .cpu_fetch, .cpu_wdata, .cpu_rdata, .cpu_ack,
        .cpu_region, .sfr_rdata, .sfr_write, .sfr_wdata, .sfr_addr,
        .timing_clock_out, .sync_out, .rw_out, .read_strobe_n,
        .write_strobe_n, .reset_out, .eprom_address_port, .eprom_data_port,
        .low_address_port, .low_address_oe_n, .high_address_port,
        .high_address_oe_n, .external_data_bus_port_in,
        .external_data_bus_port_out, .external_data_bus_port_oe_n);

    emb_ext_model u_mem (.ref_clk, .eprom_address_port, .eprom_data_port,
        .read_strobe_n, .write_strobe_n, .low_address_port,
        .external_data_bus_port_out, .external_data_bus_port_oe_n,
        .external_data_bus_port_in);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] s,
        input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One bus cycle; seen gathers oe,sfr_wr,rw_low,sync,wr,rd
    task automatic acc(input logic [15:0] a, input logic w,
        input logic f, input logic [7:0] d);
        seen = 6'h00;
        lat = 0;
        @(posedge ref_clk);
        #1;
        cpu_req = 1'b1;
        cpu_addr = a;
        cpu_we = w;
        cpu_fetch = f;
        cpu_wdata = d;
        while (cpu_ack !== 1'b1 && lat < 20)
        begin
            @(posedge ref_clk);
            #1;
            lat++;
            seen |= {~external_data_bus_port_oe_n, sfr_write, ~rw_out,
                sync_out, ~write_strobe_n, ~read_strobe_n};
        end
        cpu_req = 1'b0;
        chk("latency", 16'(lat >= 5 && lat <= 8), 16'h0001);
    endtask

    task automatic do_reset(input logic m);
        processor_mode_pin = m;
        reset_n = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1;
        chk("reset_out", 16'(reset_out), 16'h0001);
        chk("idle_pins", 16'({read_strobe_n, write_strobe_n, rw_out,
            low_address_oe_n, external_data_bus_port_oe_n}),
            16'h001f);
        reset_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("reset_out", 16'(reset_out), 16'h0000);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_clock;
        logic [7:0] v;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            #1;
            v[i] = timing_clock_out;
        end
        chk("timing_clk", 16'(v[3:0] inside {4'h3, 4'h6, 4'hc, 4'h9}
            && v[7:4] == v[3:0]), 16'h0001);
    endtask

    task automatic t_ram;
        logic [15:0] ad [5] = '{16'h0000, 16'h00bf, 16'h0100, 16'h01c0,
            16'h01ff};
        foreach (ad[i])
            acc(ad[i], 1'b1, 1'b0, ad[i][8:1] ^ 8'ha5);
        foreach (ad[i])
        begin
            acc(ad[i], 1'b0, 1'b0, 8'h00);
            chk("ram_data", 16'(cpu_rdata), 16'(ad[i][8:1] ^ 8'ha5));
            chk("ram_region", 16'(cpu_region), 16'(EMB_RAM));
            chk("ram_strobes", 16'(seen[1:0]), 16'h0000);
        end
    endtask

    task automatic t_sfr;
        acc(16'h00ff, 1'b1, 1'b0, 8'h3c);
        chk("sfr_wr", {sfr_addr, sfr_wdata}, 16'hff3c);
        chk("sfr_pulse", 16'(seen[4]), 16'h0001);
        sfr_rdata = 8'h96;
        acc(16'h00c0, 1'b0, 1'b0, 8'h00);
        chk("sfr_rd", 16'(cpu_rdata), 16'h0096);
        chk("sfr_region", 16'(cpu_region), 16'(EMB_SFR));
    endtask

    task automatic t_eprom;
        logic [15:0] ad [3] = '{16'h8000, 16'hf000, 16'hffff};
        foreach (ad[i])
        begin
            acc(ad[i], 1'b0, 1'b1, 8'h00);
            chk("eprom_addr", 16'(eprom_address_port),
                16'(ad[i][14:0]));
            chk("eprom_data", 16'(cpu_rdata),
                16'(ad[i][7:0] ^ {1'b0, ad[i][14:8]}));
            chk("fetch_pins", 16'(seen[3:0]), 16'h0004);
            chk("eprom_region", 16'(cpu_region), 16'(EMB_EPROM));
        end
    endtask

    task automatic t_ext;
        acc(16'h7e42, 1'b1, 1'b0, 8'hc3);
        chk("ext_wr_pins", 16'(seen), 16'h002a);
        chk("addr_ports", {high_address_port, low_address_port},
            16'h7e42);
        chk("addr_oe", 16'({high_address_oe_n, low_address_oe_n}),
            16'h0000);
        acc(16'h7e42, 1'b0, 1'b0, 8'h00);
        chk("ext_rd_pins", 16'(seen), 16'h0001);
        chk("ext_data", 16'(cpu_rdata), 16'h00c3);
        chk("ext_region", 16'(cpu_region), 16'(EMB_EXT));
    endtask

    task automatic t_single;
        do_reset(1'b0);
        acc(16'h7e42, 1'b0, 1'b0, 8'h00);
        chk("single_pins", 16'(seen), 16'h0000);
        chk("single_ext", 16'(cpu_rdata), 16'h0000);
        chk("single_oe", 16'({high_address_oe_n, low_address_oe_n,
            external_data_bus_port_oe_n}), 16'h0007);
        acc(16'hf000, 1'b0, 1'b1, 8'h00);
        chk("single_eprom", 16'(cpu_rdata), 16'h0070);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        do_reset(1'b1);
        t_clock();
        $display("clock test done");
        t_ram();
        $display("ram test done");
        t_sfr();
        $display("sfr test done");
        t_eprom();
        $display("eprom test done");
        t_ext();
        $display("external bus test done");
        t_single();
        $display("single-chip test done");
        final_report();
    end

    initial
    begin
        // Whole run needs about 200 cycles
        #20000;
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
